// ==== light_adc_pkg.sv ====
// shared constants for the light converter power and timing control
`default_nettype none
package light_adc_pkg;
    // ------------------------------------------------------------
    // command byte layout
    // ------------------------------------------------------------
    localparam int        CMD_SELECT_BIT   = 7;
    localparam int        TRANS_HI         = 6;
    localparam int        TRANS_LO         = 5;
    localparam int        ADDR_HI          = 4;
    localparam logic [1:0] TRANS_REPEAT    = 2'h0;
    localparam logic [1:0] TRANS_AUTO_INC  = 2'h1;
    localparam logic [1:0] TRANS_SPECIAL   = 2'h3;
    localparam logic [4:0] SF_INT_CLEAR    = 5'h01;
    localparam logic [4:0] SF_MANUAL_STOP  = 5'h02;
    localparam logic [4:0] SF_MANUAL_START = 5'h03;
    localparam logic [4:0] POINTER_RESET   = 5'h00;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [4:0] ADDR_POWER_AND_RUN_CONTROL = 5'h00;
    localparam logic [4:0] ADDR_INTEGRATION_PERIOD    = 5'h01;
    localparam int         CTRL_POWER_BIT     = 0;
    localparam int         CTRL_RUN_BIT       = 1;
    localparam int         CTRL_VALID_BIT     = 4;
    localparam int         CTRL_INTERRUPT_BIT = 5;
    localparam logic [7:0] CTRL_RESET         = 8'h00;
    localparam logic [7:0] PERIOD_RESET       = 8'h00;
    localparam logic [7:0] PERIOD_MANUAL      = 8'h00;
    localparam logic [7:0] STEP_LAST          = 8'hff;
    localparam logic [7:0] UNMAPPED_READ      = 8'h00;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 10;
    localparam int STEP_TIME_NS    = 2700000;
    localparam int STEP_CYCLES     = STEP_TIME_NS / CLK_PERIOD_NS;
    localparam int POWER_SETTLE_NS = 2000000;
endpackage
`default_nettype wire

// ==== step_tick_gen.sv ====
// divider that marks each integration step interval
`default_nettype none
module step_tick_gen
#(
    parameter int PERIOD = 270000
)
(
    input  wire logic sys_clk,
    input  wire logic reset,
    input  wire logic clk_en,
    input  wire logic run,
    output logic      tick
);
    localparam int W = $clog2(PERIOD);
    localparam logic [W-1:0] LAST = W'(PERIOD - 1);

    logic [W-1:0] count;
    logic [W-1:0] next_count;

    if (PERIOD < 2) begin : g_check
        $error("step_tick_gen PERIOD must be at least 2");
    end

    assign tick       = run && (count == LAST);
    assign next_count = (!run || tick) ? '0 : count + W'(1);

    // ------------------------------------------------------------
    // interval counter, restarts whenever integration stops
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            count <= '0;
        end else if (clk_en) begin
            count <= next_count;
        end
    end
endmodule
`default_nettype wire

// ==== step_counter.sv ====
// up counter from the programmed step value to rollover
`default_nettype none
module step_counter
(
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic       clk_en,
    input  wire logic       load,
    input  wire logic [7:0] load_value,
    input  wire logic       tick,
    output logic      [7:0] count,
    output logic            wrap
);
    import light_adc_pkg::*;

    // last step is the all-ones value, so a start of ff gives one step
    assign wrap = tick && (count == STEP_LAST);  // [R11]

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            count <= PERIOD_RESET;
        end else if (clk_en) begin
            if (load) begin
                count <= load_value;
            end else if (tick) begin
                count <= count + 8'h01;  // [R18]
            end
        end
    end
endmodule
`default_nettype wire

// ==== light_adc_power_timing_ctrl.sv ====
// power, run and integration timing control with its command byte front end
//
// What this block and its host do
// R1 - power bit 0 of control register turns converter power on and off
// R2 - run bit 1 starts integration on both channels; clearing it stops them
// R3 - conversions run only while both power and run bits are set
// R4 - host waits at least 2 ms after power before setting run; the host model waits only SETTLE clocks (50) instead
// R5 - host should program configuration before setting run
// R6 - read-only bit 5 shows the interrupt output is being driven active
// R7 - read-only bit 4 shows an integration cycle has completed
// R8 - host writes zeros to control bits 7:6 and 3:2
// R9 - control register resets to zero
// R10 - 8-bit period register sets integration length in 2.7 ms steps
// R11 - period value is two's complement of wanted step count
// R12 - period value one gives the longest period, 255 steps
// R13 - period value zero selects manual start/stop integration
// R14 - period register resets to zero, so manual mode after reset
// R15 - host avoids single-byte writes of period values above 127
// R16 - special codes 00011 start and 00010 stop manual integration
// R17 - interrupt stays active until the special interrupt-clear command
// R18 - automatic mode counts steps to rollover, flags done, restarts
`default_nettype none
module light_adc_power_timing_ctrl
    import light_adc_pkg::*;
#(
    parameter int STEP_TICKS = STEP_CYCLES
)
(
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic       clk_en,
    input  wire logic       wr_valid,
    input  wire logic       wr_first,
    input  wire logic [7:0] wr_byte,
    input  wire logic       rd_req,
    output logic      [7:0] rd_data,
    output logic            rd_valid,
    input  wire logic       interrupt_event,
    output logic            int_n_o,
    output logic            int_oe,
    output logic            power_on,
    output logic            adc_run,
    output logic            integrating,
    output logic            conversion_done,
    output logic      [7:0] integration_step_count
);
    typedef enum logic [1:0] {
        ST_OFF          = 2'b00,
        ST_AUTO         = 2'b01,
        ST_MANUAL_IDLE  = 2'b10,
        ST_MANUAL_RUN   = 2'b11
    } integ_state_t;

    if (STEP_TICKS < 2) begin : g_check
        $error("STEP_TICKS must be at least 2");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    integ_state_t state;
    integ_state_t next_state;
    logic [4:0]   pointer;
    logic         auto_inc;
    logic         power_bit;
    logic         run_bit;
    logic [7:0]   period_value;
    logic         interrupt_active_flag;
    logic         valid_flag;
    logic         tick;
    logic         wrap;
    logic [7:0]   step_count;

    // ------------------------------------------------------------
    // command byte decode
    // ------------------------------------------------------------
    // a first byte with its top bit set is always a command, which is
    // why single-byte writes cannot carry period values above 127
    wire       is_cmd      = wr_valid && wr_first && wr_byte[CMD_SELECT_BIT];  // [R15]
    wire [1:0] cmd_trans   = wr_byte[TRANS_HI:TRANS_LO];
    wire [4:0] cmd_code    = wr_byte[ADDR_HI:0];
    wire       is_special  = is_cmd && (cmd_trans == TRANS_SPECIAL);
    wire       is_address  = is_cmd && (cmd_trans != TRANS_SPECIAL);
    wire       is_data     = wr_valid && !is_cmd;
    wire       cmd_int_clr = is_special && (cmd_code == SF_INT_CLEAR);
    wire       cmd_start   = is_special && (cmd_code == SF_MANUAL_START);
    wire       cmd_stop    = is_special && (cmd_code == SF_MANUAL_STOP);
    wire       wr_ctrl     = is_data && (pointer == ADDR_POWER_AND_RUN_CONTROL);
    wire       wr_period   = is_data && (pointer == ADDR_INTEGRATION_PERIOD);
    wire       step_ptr    = auto_inc && (is_data || rd_req);

    // ------------------------------------------------------------
    // register write and readback
    // ------------------------------------------------------------
    // only power and run are stored; the other control bits are dropped
    wire       next_power  = wr_ctrl ? wr_byte[CTRL_POWER_BIT] : power_bit;  // [R1] [R8]
    wire       next_run    = wr_ctrl ? wr_byte[CTRL_RUN_BIT] : run_bit;  // [R2]
    wire       enabled     = power_bit && run_bit;  // [R3]
    wire       manual_mode = (period_value == PERIOD_MANUAL);  // [R13]
    wire [7:0] ctrl_read   = {2'h0, interrupt_active_flag, valid_flag, 2'h0, run_bit, power_bit};  // [R6] [R7]
    wire [7:0] sel_read    = (pointer == ADDR_POWER_AND_RUN_CONTROL) ? ctrl_read :
                             (pointer == ADDR_INTEGRATION_PERIOD)    ? period_value :
                                                                       UNMAPPED_READ;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            power_bit    <= CTRL_RESET[CTRL_POWER_BIT];  // [R9]
            run_bit      <= CTRL_RESET[CTRL_RUN_BIT];
            period_value <= PERIOD_RESET;  // [R14]
        end else if (clk_en) begin
            power_bit <= next_power;
            run_bit   <= next_run;
            if (wr_period) begin
                period_value <= wr_byte;  // [R10]
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pointer  <= POINTER_RESET;
            auto_inc <= 1'b0;
        end else if (clk_en) begin
            if (is_address) begin
                pointer  <= cmd_code;
                auto_inc <= (cmd_trans == TRANS_AUTO_INC);
            end else if (step_ptr) begin
                pointer <= pointer + 5'h01;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rd_data  <= UNMAPPED_READ;
            rd_valid <= 1'b0;
        end else if (clk_en) begin
            rd_valid <= rd_req;
            if (rd_req) begin
                rd_data <= sel_read;
            end
        end
    end

    // ------------------------------------------------------------
    // integration sequencing
    // ------------------------------------------------------------
    wire manual_end = (state == ST_MANUAL_RUN) && cmd_stop;  // [R16]
    wire cycle_end  = (state == ST_AUTO && wrap) || manual_end;
    wire load_steps = (state != ST_AUTO && next_state == ST_AUTO) || (state == ST_AUTO && wrap);

    always_comb begin
        next_state = state;
        case (state)
            ST_OFF: begin
                if (enabled) begin
                    next_state = manual_mode ? ST_MANUAL_IDLE : ST_AUTO;  // [R2] [R13]
                end
            end
            ST_AUTO: begin
                // a switch to manual takes effect only at the end of an integration cycle (wrap)
                if (wrap && manual_mode) begin
                    next_state = ST_MANUAL_IDLE;
                end
            end
            ST_MANUAL_IDLE: begin
                if (!manual_mode) begin
                    next_state = ST_AUTO;
                end else if (cmd_start) begin
                    next_state = ST_MANUAL_RUN;  // [R16]
                end
            end
            ST_MANUAL_RUN: begin
                if (cmd_stop) begin
                    next_state = ST_MANUAL_IDLE;  // [R16]
                end
            end
            default: begin
                next_state = ST_OFF;
            end
        endcase
        if (!enabled) begin
            next_state = ST_OFF;  // [R3]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state <= ST_OFF;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    step_tick_gen #(
        .PERIOD (STEP_TICKS)
    ) u_tick (
        .sys_clk (sys_clk),
        .reset   (reset),
        .clk_en  (clk_en),
        .run     (integrating),
        .tick    (tick)
    );

    // the period is sampled at each cycle start, so a rewrite mid-cycle
    // only lengthens or shortens the next cycle
    step_counter u_steps (
        .sys_clk    (sys_clk),
        .reset      (reset),
        .clk_en     (clk_en),
        .load       (load_steps),
        .load_value (period_value),
        .tick       (tick),
        .count      (step_count),
        .wrap       (wrap)
    );  // [R12] [R18]

    // ------------------------------------------------------------
    // status flags, a new event wins over a clear in the same cycle
    // ------------------------------------------------------------
    wire valid_clear = wr_ctrl && !wr_byte[CTRL_RUN_BIT];

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            valid_flag            <= 1'b0;
            interrupt_active_flag <= 1'b0;
            conversion_done       <= 1'b0;
        end else if (clk_en) begin
            conversion_done <= cycle_end;
            if (cycle_end) begin
                valid_flag <= 1'b1;  // [R7] [R18]
            end else if (valid_clear) begin
                valid_flag <= 1'b0;
            end
            if (interrupt_event) begin
                interrupt_active_flag <= 1'b1;
            end else if (cmd_int_clr) begin
                interrupt_active_flag <= 1'b0;  // [R17]
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign power_on               = power_bit;  // [R1]
    assign adc_run                = run_bit;  // [R2]
    assign integrating            = (state == ST_AUTO) || (state == ST_MANUAL_RUN);
    assign integration_step_count = step_count;
    assign int_n_o                = 1'b0;
    assign int_oe                 = interrupt_active_flag;  // [R6] [R17]
endmodule
`default_nettype wire

// ==== light_adc_power_timing_ctrl_assertions.sv ====
// port-level checks for the power, run and integration timing control
`default_nettype none
module light_adc_power_timing_ctrl_assertions import light_adc_pkg::*; #(
    parameter int STEP_TICKS = 4
) (
    input wire logic       sys_clk,
    input wire logic       reset,
    input wire logic       clk_en,
    input wire logic       wr_valid,
    input wire logic       wr_first,
    input wire logic [7:0] wr_byte,
    input wire logic       rd_req,
    input wire logic [7:0] rd_data,
    input wire logic       rd_valid,
    input wire logic       interrupt_event,
    input wire logic       int_n_o,
    input wire logic       int_oe,
    input wire logic       power_on,
    input wire logic       adc_run,
    input wire logic       integrating,
    input wire logic       conversion_done,
    input wire logic [7:0] integration_step_count
);
    // ----------------------------------------
    // command sequences
    // ----------------------------------------
    localparam logic [7:0] CTRL_PTR = {1'b1, TRANS_REPEAT, ADDR_POWER_AND_RUN_CONTROL};
    localparam logic [7:0] INT_CLR  = {1'b1, TRANS_SPECIAL, SF_INT_CLEAR};
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    sequence s_cmd(logic [7:0] c);
        clk_en && wr_valid && wr_first && wr_byte == c;
    endsequence
    sequence s_data;
        clk_en && wr_valid && !wr_first;
    endsequence
    property p_ctrl_write;
        s_cmd(CTRL_PTR) ##1 s_data |=> ($past(wr_byte) & 8'h03) == {6'h00, adc_run, power_on};
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control write not applied");
    property p_off;
        !(power_on && adc_run) |=> !integrating;
    endproperty
    a_off: assert property (p_off) else $error("integrating without power and run");
    property p_int_set;
        clk_en && interrupt_event |=> int_oe;
    endproperty
    a_int_set: assert property (p_int_set) else $error("interrupt not raised");
    property p_int_cause;
        clk_en && !int_oe && !interrupt_event |=> !int_oe;
    endproperty
    a_int_cause: assert property (p_int_cause) else $error("interrupt without event");
    property p_int_hold;
        int_oe && !(wr_valid && wr_first && wr_byte == INT_CLR) |=> int_oe;
    endproperty
    a_int_hold: assert property (p_int_hold) else $error("interrupt dropped early");
    property p_int_clear;
        s_cmd(INT_CLR) ##0 !interrupt_event |=> !int_oe && !int_n_o;
    endproperty
    a_int_clear: assert property (p_int_clear) else $error("interrupt not cleared");
    property p_step;
        clk_en && integrating && integration_step_count != STEP_LAST ##1 integrating
            && $changed(integration_step_count) |-> integration_step_count == $past(integration_step_count) + 8'h01;
    endproperty
    a_step: assert property (p_step) else $error("step count jumped");
    property p_done;
        clk_en && conversion_done |=> !conversion_done;
    endproperty
    a_done: assert property (p_done) else $error("done longer than one cycle");
    // reset itself is the cause here, so this one is never disabled
    property p_rst;
        disable iff (1'b0) reset && clk_en |=> !power_on && !adc_run && !int_oe && !integrating
            && integration_step_count == 8'h00;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
endmodule
bind light_adc_power_timing_ctrl light_adc_power_timing_ctrl_assertions #(.STEP_TICKS(STEP_TICKS)) chk_i (
    .sys_clk, .reset, .clk_en, .wr_valid, .wr_first, .wr_byte, .rd_req, .rd_data, .rd_valid, .interrupt_event,
    .int_n_o, .int_oe, .power_on, .adc_run, .integrating, .conversion_done, .integration_step_count);
`default_nettype wire

// ==== host_bus_model.sv ====
// host side model: command and data bytes, reads, power-up order
`default_nettype none
module host_bus_model import light_adc_pkg::*; #(
    parameter int SETTLE = 50
) (
    input  wire logic       sys_clk,
    input  wire logic [7:0] rd_data,
    input  wire logic       rd_valid,
    output logic            wr_valid = 1'b0,
    output logic            wr_first = 1'b0,
    output logic      [7:0] wr_byte  = 8'h00,
    output logic            rd_req   = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    task automatic send(input logic first, input logic [7:0] b);
        @(posedge sys_clk);
        wr_valid <= 1'b1;
        wr_first <= first;
        wr_byte  <= b;
    endtask
    // released data toggles so a stale byte never looks held
    task automatic idle();
        @(posedge sys_clk);
        wr_valid <= 1'b0;
        wr_first <= 1'b0;
        wr_byte  <= ~wr_byte;
    endtask
    task automatic cmd(input logic [7:0] c);
        send(1'b1, c);
        idle();
    endtask
    // command byte always leads, so values above 127 are never mistaken for commands
    task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
        send(1'b1, {1'b1, TRANS_REPEAT, a});
        send(1'b0, d);
        idle();
    endtask
    task automatic rd_reg(input logic [4:0] a, output logic [7:0] d, output logic v);
        cmd({1'b1, TRANS_REPEAT, a});
        @(posedge sys_clk);
        rd_req <= 1'b1;
        @(posedge sys_clk);
        rd_req <= 1'b0;
        #1;
        d = rd_data;
        v = rd_valid;
    endtask
    task automatic wr_ctrl(input logic [7:0] d);
        wr_reg(ADDR_POWER_AND_RUN_CONTROL, d & 8'h03);
    endtask
    // settle is scaled down; the real wait is far longer than a sim run
    task automatic start();
        wr_ctrl(8'h01);
        repeat (SETTLE) @(posedge sys_clk);
        wr_ctrl(8'h03);
    endtask
endmodule
`default_nettype wire

// ==== light_adc_power_timing_ctrl_tb.sv ====
// self-checking bench for the power, run and integration timing control
`default_nettype none
module light_adc_power_timing_ctrl_tb import light_adc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int ST = 4;
    logic       sys_clk = 1'b0;
    logic       reset = 1'b1;
    logic       clk_en = 1'b1;
    logic       interrupt_event = 1'b0;
    logic       wr_valid, wr_first, rd_req, rd_valid, int_n_o, int_oe;
    logic       power_on, adc_run, integrating, conversion_done, v;
    logic [7:0] wr_byte, rd_data, integration_step_count, d, p;
    int         failures = 0, checks_done = 0, cyc = 0, ndone = 0, n, seed = 32'hb93d2752;
    light_adc_power_timing_ctrl #(.STEP_TICKS(ST)) dut (.sys_clk, .reset, .clk_en, .wr_valid, .wr_first,
        .wr_byte, .rd_req, .rd_data, .rd_valid, .interrupt_event, .int_n_o, .int_oe, .power_on, .adc_run,
        .integrating, .conversion_done, .integration_step_count);
    host_bus_model #(.SETTLE(50)) host (.sys_clk, .rd_data, .rd_valid, .wr_valid, .wr_first, .wr_byte, .rd_req);
    always #5 sys_clk = ~sys_clk;
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic test_done();
        $display("checks %0d, failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (conversion_done === 1'b1) ndone <= ndone + 1;
        if (cyc == 40000) begin
            failures = failures + 1;
            test_done();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic int exp_cycles(input logic [7:0] per);
        return (256 - int'(per)) * ST;
    endfunction
    task automatic settle(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask
    task automatic wait_done(output int cnt);
        cnt = 0;
        do begin
            settle(1);
            cnt++;
        end while (conversion_done !== 1'b1 && cnt < 3000);
    endtask
    // first cycle after entry is not timed; the second is the full period
    task automatic auto_run(input logic [7:0] per);
        host.wr_ctrl(8'h00);
        host.wr_reg(ADDR_INTEGRATION_PERIOD, per);
        host.start();
        wait_done(n);
        wait_done(n);
        chk(16'(n), 16'(exp_cycles(per)));
        chk({8'h00, integration_step_count}, {8'h00, per});
        host.rd_reg(ADDR_POWER_AND_RUN_CONTROL, d, v);
        chk({7'h00, v, d}, 16'h0113);
        $display("auto test done, period %h", per);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        host.rd_reg(ADDR_POWER_AND_RUN_CONTROL, d, v);
        chk({7'h00, v, d}, 16'h0100);
        host.rd_reg(ADDR_INTEGRATION_PERIOD, d, v);
        chk({7'h00, v, d}, 16'h0100);
        host.rd_reg(5'h05, d, v);
        chk({7'h00, v, d}, {7'h00, 1'b1, UNMAPPED_READ});
        p = 8'($random(seed));
        host.wr_reg(ADDR_INTEGRATION_PERIOD, p);
        host.rd_reg(ADDR_INTEGRATION_PERIOD, d, v);
        chk({8'h00, d}, {8'h00, p});
        $display("register test done");
        auto_run(8'hff);
        auto_run(8'hfe);
        auto_run(8'h01);
        auto_run({2'b11, 6'($random(seed))});
        // clock enable low must freeze the step counter and the state mid-cycle
        @(posedge sys_clk);
        clk_en <= 1'b0;
        settle(1);
        p = integration_step_count;
        settle(8);
        chk({8'h00, integration_step_count}, {8'h00, p});
        chk({15'h0000, integrating}, 16'h0001);
        @(posedge sys_clk);
        clk_en <= 1'b1;
        $display("clock enable test done");
        host.wr_ctrl(8'h00);
        host.wr_reg(ADDR_INTEGRATION_PERIOD, PERIOD_MANUAL);
        host.start();
        settle(4);
        chk(integrating, 1'b0);
        host.cmd({1'b1, TRANS_SPECIAL, SF_MANUAL_START});
        settle(4);
        chk(integrating, 1'b1);
        n = ndone;
        host.cmd({1'b1, TRANS_SPECIAL, SF_MANUAL_STOP});
        settle(4);
        chk(16'(ndone - n), 16'h0001);
        chk(integrating, 1'b0);
        $display("manual test done");
        @(posedge sys_clk);
        interrupt_event <= 1'b1;
        @(posedge sys_clk);
        interrupt_event <= 1'b0;
        settle(1);
        chk({int_oe, int_n_o}, 16'h0002);
        host.rd_reg(ADDR_POWER_AND_RUN_CONTROL, d, v);
        chk({8'h00, d & 8'h20}, 16'h0020);
        settle(5 + ($random(seed) & 31));
        chk(int_oe, 1'b1);
        host.cmd({1'b1, TRANS_SPECIAL, SF_INT_CLEAR});
        settle(2);
        chk(int_oe, 1'b0);
        $display("interrupt test done");
        host.wr_ctrl(8'h00);
        settle(3);
        chk({power_on, adc_run, integrating}, 16'h0000);
        $display("power down test done");
        test_done();
    end
endmodule
`default_nettype wire
